//--- design/lcd_seg_ctrl.sv
// segment display command/status, segment memory and apb register slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module lcd_seg_ctrl
  import lcd_seg_pkg::*;
#(
  parameter int NUM_FP       = 8,
  parameter int SLOT_CYCLES  = lcd_seg_pkg::SLOT_CYCLES,
  parameter int BLINK_FRAMES = lcd_seg_pkg::BLINK_FRAMES
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              resetn_i,
  input  wire logic [lcd_seg_pkg::APB_AW-1:0]    paddr_i,
  input  wire logic                              psel_i,
  input  wire logic                              penable_i,
  input  wire logic                              pwrite_i,
  input  wire logic [31:0]                       pwdata_i,
  output logic [31:0]                            prdata_o,
  output logic                                   pready_o,
  output logic                                   pslverr_o,
  output logic                                   irq_o,
  output logic [2*lcd_seg_pkg::NUM_BP-1:0]       bp_level_o,
  output logic [lcd_seg_pkg::NUM_BP-1:0]         bp_drive_o,
  output logic [2*NUM_FP-1:0]                    fp_level_o,
  output logic [NUM_FP-1:0]                      fp_display_o
);
  import lcd_seg_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic                  frame_irq_flag;
    logic                  seg_mem_group_sel;
    logic                  blank;
    logic                  clr_pend;
    logic                  clr_grp;
    logic                  display_module_en;
    logic                  blink_cmd;
    logic                  frame_irq_en;
    logic [1:0]            duty;
    logic [NUM_FP-1:0]     frontplane_pin_en;
    logic [NUM_FP*4-1:0]   segment_memory;
    logic [NUM_FP*4-1:0]   blink_memory;
    logic                  flag_armed;
    logic                  blink_act;
    logic                  blink_phase;
    logic [7:0]            blink_cnt;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  irq;
  } ctrl_state_type;

  ctrl_state_type st_r;
  ctrl_state_type st_nxt;

  lcd_wave_if #(.NUM_FP(NUM_FP)) wif ();

  logic              acc;
  logic              done;
  logic              hit;
  logic              seg_hit;
  int                seg_idx;
  logic [31:0]       rd_val;
  logic [3:0]        sel_nib;
  logic              cmd_wr;
  logic              cmd_rd;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // index of a segment memory word, or -1 when the address is not one
  function automatic int seg_index(input logic [APB_AW-1:0] a);
    int idx;
    idx = -1;
    for (int n = 0; n < NUM_FP; n++) begin
      if (a == APB_AW'(SEGMENT_MEMORY_OFS + 8'(4 * n)))
        idx = n;
    end
    return idx;
  endfunction

  // read mux; reserved bits and the clear command read as zero
  always_comb begin
    seg_idx = seg_index(paddr_i);
    seg_hit = (seg_idx >= 0);
    hit     = seg_hit || paddr_i == LCD_COMMAND_STATUS_OFS
              || paddr_i == DISPLAY_CONTROL0_OFS || paddr_i == FRONTPLANE_EN_OFS;
    sel_nib = '0;
    if (seg_hit)
      sel_nib = st_r.seg_mem_group_sel ? st_r.blink_memory[4*seg_idx +: 4]
                                       : st_r.segment_memory[4*seg_idx +: 4];
    rd_val = '0;
    if (paddr_i == LCD_COMMAND_STATUS_OFS) begin
      rd_val[FRAME_IRQ_FLAG_BIT]    = st_r.frame_irq_flag;
      rd_val[SEG_MEM_GROUP_SEL_BIT] = st_r.seg_mem_group_sel;
      rd_val[SEG_MEM_CLEAR_CMD_BIT] = 1'b0;
      rd_val[BLANK_BIT]             = st_r.blank;
    end else if (paddr_i == DISPLAY_CONTROL0_OFS) begin
      rd_val[DISPLAY_MODULE_EN_BIT] = st_r.display_module_en;
      rd_val[BLINK_CMD_BIT]         = st_r.blink_cmd;
      rd_val[FRAME_IRQ_EN_BIT]      = st_r.frame_irq_en;
      rd_val[DUTY_LSB +: 2]         = st_r.duty;
    end else if (paddr_i == FRONTPLANE_EN_OFS) begin
      rd_val[NUM_FP-1:0] = st_r.frontplane_pin_en;
    end else if (seg_hit) begin
      rd_val[3:0] = sel_nib;
    end
  end

  // apb phases: data is prepared in the first access cycle, committed on the second
  assign acc    = psel_i & penable_i;
  assign done   = acc & st_r.pready;
  assign cmd_wr = done & pwrite_i & (paddr_i == LCD_COMMAND_STATUS_OFS);
  assign cmd_rd = done & ~pwrite_i & (paddr_i == LCD_COMMAND_STATUS_OFS);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // bus answer, registered so every bus output comes from a flop
    if (acc && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = ~hit;
      st_nxt.prdata  = rd_val;
    end else begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end
    // a pending clear wipes its group one cycle after the command write
    if (st_r.clr_pend) begin
      if (st_r.clr_grp)
        st_nxt.blink_memory = '0;
      else
        st_nxt.segment_memory = '0;
      st_nxt.clr_pend = 1'b0;
    end
    // a read that sees the flag set arms the write-one clear
    if (cmd_rd)
      st_nxt.flag_armed = st_r.frame_irq_flag;
    // register writes
    if (done && pwrite_i && hit) begin
      if (paddr_i == LCD_COMMAND_STATUS_OFS) begin
        st_nxt.seg_mem_group_sel = pwdata_i[SEG_MEM_GROUP_SEL_BIT];
        st_nxt.blank             = pwdata_i[BLANK_BIT];
        if (pwdata_i[SEG_MEM_CLEAR_CMD_BIT]) begin
          st_nxt.clr_pend = 1'b1;
          st_nxt.clr_grp  = pwdata_i[SEG_MEM_GROUP_SEL_BIT];
        end
        if (pwdata_i[FRAME_IRQ_FLAG_BIT] && st_r.flag_armed)
          st_nxt.frame_irq_flag = 1'b0;
        st_nxt.flag_armed = 1'b0;
      end else if (paddr_i == DISPLAY_CONTROL0_OFS) begin
        st_nxt.display_module_en = pwdata_i[DISPLAY_MODULE_EN_BIT];
        st_nxt.blink_cmd         = pwdata_i[BLINK_CMD_BIT];
        st_nxt.frame_irq_en      = pwdata_i[FRAME_IRQ_EN_BIT];
        st_nxt.duty              = pwdata_i[DUTY_LSB +: 2];
      end else if (paddr_i == FRONTPLANE_EN_OFS) begin
        st_nxt.frontplane_pin_en = pwdata_i[NUM_FP-1:0];
      end else if (st_r.seg_mem_group_sel) begin
        st_nxt.blink_memory[4*seg_idx +: 4] = pwdata_i[3:0];
      end else begin
        st_nxt.segment_memory[4*seg_idx +: 4] = pwdata_i[3:0];
      end
    end
    // frame event: set wins over a clear in the same cycle
    if (wif.frame_start) begin
      st_nxt.frame_irq_flag = 1'b1;
      // blink command is sampled only on a frame boundary
      st_nxt.blink_act = st_r.blink_cmd;
      if (st_r.blink_cmd) begin
        if (st_r.blink_cnt == 8'(BLINK_FRAMES - 1)) begin
          st_nxt.blink_cnt   = '0;
          st_nxt.blink_phase = ~st_r.blink_phase;
        end else begin
          st_nxt.blink_cnt = st_r.blink_cnt + 8'd1;
        end
      end else begin
        st_nxt.blink_cnt   = '0;
        st_nxt.blink_phase = 1'b0;
      end
    end
    // level interrupt from flag and mask
    st_nxt.irq = st_nxt.frame_irq_flag & st_nxt.frame_irq_en;
  end

  // state register; reset zeroes every field, then loads the documented defaults
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r                   <= '0;
      st_r.frame_irq_flag    <= CMD_STATUS_RST[FRAME_IRQ_FLAG_BIT];
      st_r.seg_mem_group_sel <= CMD_STATUS_RST[SEG_MEM_GROUP_SEL_BIT];
      st_r.blank             <= CMD_STATUS_RST[BLANK_BIT];
      st_r.display_module_en <= DISPLAY_CONTROL0_RST[DISPLAY_MODULE_EN_BIT];
      st_r.blink_cmd         <= DISPLAY_CONTROL0_RST[BLINK_CMD_BIT];
      st_r.frame_irq_en      <= DISPLAY_CONTROL0_RST[FRAME_IRQ_EN_BIT];
      st_r.duty              <= DISPLAY_CONTROL0_RST[DUTY_LSB +: 2];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // feed to the waveform generator
  // ------------------------------------------------------------
  // blank only masks what is shown; memory and timing are left alone
  always_comb begin
    wif.run   = st_r.display_module_en;
    wif.duty  = st_r.duty;
    wif.fp_en = st_r.frontplane_pin_en;
    if (st_r.blank)
      wif.seg_on = '0;
    else if (st_r.blink_act && st_r.blink_phase)
      wif.seg_on = st_r.segment_memory & ~st_r.blink_memory;
    else
      wif.seg_on = st_r.segment_memory;
  end

  lcd_wave_gen #(
    .NUM_FP      (NUM_FP),
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_wave (
    .core_clk_i   (core_clk_i),
    .resetn_i     (resetn_i),
    .w            (wif),
    .bp_level_o   (bp_level_o),
    .bp_drive_o   (bp_drive_o),
    .fp_level_o   (fp_level_o),
    .fp_display_o (fp_display_o)
  );

  assign prdata_o  = st_r.prdata;
  assign pready_o  = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign irq_o     = st_r.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  clear_reads_zero_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (acc && !st_r.pready && !pwrite_i && paddr_i == LCD_COMMAND_STATUS_OFS)
    |=> prdata_o[SEG_MEM_CLEAR_CMD_BIT] == 1'b0)
    else $error("clear command bit read back as one");

  flag_sets_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    wif.frame_start |=> st_r.frame_irq_flag)
    else $error("frame event did not set the flag");

  flag_clear_armed_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (cmd_wr && pwdata_i[FRAME_IRQ_FLAG_BIT] && st_r.flag_armed && !wif.frame_start)
    |=> !st_r.frame_irq_flag)
    else $error("armed write of one did not clear the flag");

  flag_needs_read_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (cmd_wr && st_r.frame_irq_flag && !st_r.flag_armed) |=> st_r.frame_irq_flag)
    else $error("flag cleared without a prior read");

  group_read_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (acc && !st_r.pready && !pwrite_i && seg_hit) |=> prdata_o[3:0] == $past(sel_nib)
      && prdata_o[3:0] == ($past(st_r.seg_mem_group_sel)
         ? $past(st_r.blink_memory[4*seg_idx +: 4])
         : $past(st_r.segment_memory[4*seg_idx +: 4])))
    else $error("segment read came from the wrong group");

  clear_group_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (cmd_wr && pwdata_i[SEG_MEM_CLEAR_CMD_BIT]) |=> st_r.clr_pend
      ##1 (!st_r.clr_pend && (st_r.clr_grp ? st_r.blink_memory == '0
                                           : st_r.segment_memory == '0)))
    else $error("clear command did not empty its group and drop");

  blank_shows_off_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    st_r.blank |-> wif.seg_on == '0)
    else $error("segment shown while blanked");

  blank_keeps_mem_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (st_r.blank && !(done && pwrite_i) && !st_r.clr_pend)
    |=> $stable(st_r.segment_memory) && $stable(st_r.blink_memory))
    else $error("memory changed by blanking");

  blink_at_frame_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !wif.frame_start |=> $stable(st_r.blink_act))
    else $error("blink state changed inside a frame");

  irq_level_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ##1 irq_o == (st_r.frame_irq_flag && st_r.frame_irq_en))
    else $error("interrupt output disagrees with flag and mask");

  clear_cmd_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    cmd_wr && pwdata_i[SEG_MEM_CLEAR_CMD_BIT]);

  flag_cleared_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(st_r.frame_irq_flag));

  blink_on_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    st_r.blink_act && st_r.blink_phase);

endmodule

//--- design/lcd_wave_gen.sv
// frame timer and 1/3-bias level generator for backplanes and frontplanes
`timescale 1ns/1ns
module lcd_wave_gen
  import lcd_seg_pkg::*;
#(
  parameter int NUM_FP      = 8,
  parameter int SLOT_CYCLES = lcd_seg_pkg::SLOT_CYCLES
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  lcd_wave_if.wave                   w,
  output logic [2*NUM_BP-1:0]        bp_level_o,
  output logic [NUM_BP-1:0]          bp_drive_o,
  output logic [2*NUM_FP-1:0]        fp_level_o,
  output logic [NUM_FP-1:0]          fp_display_o
);

  typedef struct packed {
    logic [31:0]         tick_cnt;
    logic [1:0]          slot;
    logic                phase;
    logic                frame_start;
    logic [2*NUM_BP-1:0] bp_lvl;
    logic [NUM_BP-1:0]   bp_drv;
    logic [2*NUM_FP-1:0] fp_lvl;
    logic [NUM_FP-1:0]   fp_disp;
  } wave_state_type;

  wave_state_type st_r;
  wave_state_type st_nxt;
  logic [NUM_BP-1:0] active;

  // ------------------------------------------------------------
  // slot sequencing and level selection
  // ------------------------------------------------------------
  // levels are chosen from the next slot/phase so pins change on the slot edge
  always_comb begin
    st_nxt             = st_r;
    st_nxt.frame_start = 1'b0;
    active             = w.run ? active_bp_mask(w.duty) : '0;
    if (!w.run || w.duty == DUTY_RSVD) begin
      st_nxt.tick_cnt = '0;
      st_nxt.slot     = '0;
      st_nxt.phase    = 1'b0;
    end else if (st_r.tick_cnt == 32'(SLOT_CYCLES - 1)) begin
      st_nxt.tick_cnt = '0;
      if (st_r.slot >= w.duty) begin
        st_nxt.slot        = '0;
        st_nxt.phase       = ~st_r.phase; // inverting each frame keeps the glass free of dc
        st_nxt.frame_start = 1'b1;
      end else begin
        st_nxt.slot = st_r.slot + 2'd1;
      end
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'd1;
    end
    for (int b = 0; b < NUM_BP; b++) begin
      st_nxt.bp_drv[b] = active[b];
      if (!active[b])
        st_nxt.bp_lvl[2*b +: 2] = LVL_V0;
      else if (st_nxt.slot == 2'(b))
        st_nxt.bp_lvl[2*b +: 2] = st_nxt.phase ? LVL_V0 : LVL_V3;
      else
        st_nxt.bp_lvl[2*b +: 2] = st_nxt.phase ? LVL_V2 : LVL_V1;
    end
    for (int n = 0; n < NUM_FP; n++) begin
      st_nxt.fp_disp[n] = w.run & w.fp_en[n];
      if (!st_nxt.fp_disp[n] || w.duty == DUTY_RSVD)
        st_nxt.fp_lvl[2*n +: 2] = LVL_V0;
      else if (w.seg_on[4*n + int'(st_nxt.slot)])
        st_nxt.fp_lvl[2*n +: 2] = st_nxt.phase ? LVL_V3 : LVL_V0;
      else
        st_nxt.fp_lvl[2*n +: 2] = st_nxt.phase ? LVL_V1 : LVL_V2;
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign w.frame_start = st_r.frame_start;
  assign bp_level_o    = st_r.bp_lvl;
  assign bp_drive_o    = st_r.bp_drv;
  assign fp_level_o    = st_r.fp_lvl;
  assign fp_display_o  = st_r.fp_disp;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  fp_pin_gating_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ##1 fp_display_o == ($past(w.run) ? $past(w.fp_en) : '0))
    else $error("frontplane pin display state does not follow enables");

  duty_backplanes_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ##1 bp_drive_o == ($past(w.run) ? active_bp_mask($past(w.duty)) : '0))
    else $error("driven backplanes do not match duty");

  slot_ascending_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (w.run && w.duty != DUTY_RSVD && st_r.tick_cnt == 32'(SLOT_CYCLES - 1)
     && st_r.slot < w.duty) |=> st_r.slot == $past(st_r.slot) + 2'd1)
    else $error("backplane slot did not advance by one");

  frame_wrap_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (w.run && st_r.tick_cnt == 32'(SLOT_CYCLES - 1) && st_r.slot == w.duty
     && w.duty != DUTY_RSVD) |=> (st_r.slot == 2'd0) && st_r.frame_start)
    else $error("frame did not wrap after last active backplane");

  frame_seen_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    st_r.frame_start && w.duty == DUTY_QUARTER);

endmodule

//--- pkg/lcd_seg_pkg.sv
// constants, types and helpers shared by the segment display controller
package lcd_seg_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one aligned 32-bit word each)
  // ------------------------------------------------------------
  localparam int            APB_AW                   = 8;
  localparam logic [7:0]    LCD_COMMAND_STATUS_OFS   = 8'h00;
  localparam logic [7:0]    DISPLAY_CONTROL0_OFS     = 8'h04;
  localparam logic [7:0]    FRONTPLANE_EN_OFS        = 8'h08;
  localparam logic [7:0]    SEGMENT_MEMORY_OFS       = 8'h10;

  // command/status field positions
  localparam int            FRAME_IRQ_FLAG_BIT       = 7;
  localparam int            SEG_MEM_GROUP_SEL_BIT    = 3;
  localparam int            SEG_MEM_CLEAR_CMD_BIT    = 1;
  localparam int            BLANK_BIT                = 0;

  // display control0 field positions
  localparam int            DISPLAY_MODULE_EN_BIT    = 7;
  localparam int            BLINK_CMD_BIT            = 6;
  localparam int            FRAME_IRQ_EN_BIT         = 5;
  localparam int            DUTY_LSB                 = 0;

  // values after reset
  localparam logic [7:0]    CMD_STATUS_RST           = 8'h00;
  localparam logic [7:0]    DISPLAY_CONTROL0_RST     = 8'h03;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int            CLK_PERIOD_NS            = 4;
  localparam int            SLOT_TIME_NS             = 1000000;
  localparam int            SLOT_CYCLES              = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int            BLINK_FRAMES             = 16;
  localparam int            NUM_BP                   = 4;

  typedef enum logic [1:0] {DUTY_RSVD, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} duty_type;
  typedef enum logic [1:0] {LVL_V0, LVL_V1, LVL_V2, LVL_V3} level_type;

  // backplanes driven for a duty setting; reserved drives none
  function automatic logic [NUM_BP-1:0] active_bp_mask(input logic [1:0] duty);
    unique case (duty)
      DUTY_HALF:    active_bp_mask = 4'b0011;
      DUTY_THIRD:   active_bp_mask = 4'b0111;
      DUTY_QUARTER: active_bp_mask = 4'b1111;
      DUTY_RSVD:    active_bp_mask = 4'b0000;
    endcase
  endfunction

endpackage

//--- pkg/lcd_wave_if.sv
// signals between the register side and the waveform generator
`timescale 1ns/1ns
interface lcd_wave_if #(
  parameter int NUM_FP = 8
);
  logic              run;
  logic [1:0]        duty;
  logic [NUM_FP*4-1:0] seg_on;
  logic [NUM_FP-1:0] fp_en;
  logic              frame_start;

  modport ctrl (output run, output duty, output seg_on, output fp_en, input frame_start);
  modport wave (input run, input duty, input seg_on, input fp_en, output frame_start);
endinterface

//--- verification/lcd_glass_model.sv
// passive multiplexed glass: reports which segments see full drive
`timescale 1ns/1ns
module lcd_glass_model #(
  parameter int NUM_FP = 8
) (
  input  wire logic [7:0]          bp_level_i,
  input  wire logic [3:0]          bp_drive_i,
  input  wire logic [2*NUM_FP-1:0] fp_level_i,
  input  wire logic [NUM_FP-1:0]   fp_display_i,
  output logic      [4*NUM_FP-1:0] seg_lit_o
);
  // only the full V0/V3 swing energises a cell; V1/V2 pairs stay dark
  always_comb begin
    for (int n = 0; n < NUM_FP; n++) begin
      for (int b = 0; b < 4; b++) begin
        seg_lit_o[4*n+b] = bp_drive_i[b] && fp_display_i[n] &&
          ({bp_level_i[2*b+:2], fp_level_i[2*n+:2]} inside {4'hC, 4'h3});
      end
    end
  end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the segment display controller
`timescale 1ns/1ns
module tb_top;
  import lcd_seg_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic e;} row_type;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata, rd, seg_lit;
  logic        pready, pslverr, irq, err;
  logic [7:0]  bp_level, fp_display;
  logic [3:0]  bp_drive;
  logic [15:0] fp_level;
  int          err_total = 0, comparisons = 0, cyc = 0, lit, n;
  // rows: write, address, data (write) or expected data (read), expected error
  row_type     rows [10] = '{
    '{1, 8'h08, 8'h01, 0}, '{0, 8'h08, 8'h01, 0}, '{1, 8'h10, 8'h0F, 0},
    '{0, 8'h10, 8'h0F, 0}, '{1, 8'h14, 8'h05, 0}, '{0, 8'h14, 8'h05, 0},
    '{1, 8'h04, 8'hA3, 0}, '{0, 8'h04, 8'hA3, 0},
    '{1, 8'h0C, 8'h55, 1}, '{0, 8'h0C, 8'h00, 1}};

  always #2 core_clk = ~core_clk;

  lcd_seg_ctrl #(.SLOT_CYCLES(4), .BLINK_FRAMES(2)) uut (
    .core_clk_i(core_clk), .resetn_i(resetn), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .bp_level_o(bp_level),
    .bp_drive_o(bp_drive), .fp_level_o(fp_level), .fp_display_o(fp_display));
  lcd_glass_model glass (.bp_level_i(bp_level), .bp_drive_i(bp_drive),
    .fp_level_i(fp_level), .fp_display_i(fp_display), .seg_lit_o(seg_lit));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, 24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) err_total++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, 32'(exp));
  endtask
  // a 48-cycle window spans whole frames for every duty
  task automatic count_lit;
    lit = 0;
    repeat (16) @(posedge core_clk);
    repeat (48) begin
      @(posedge core_clk);
      lit += $countones(seg_lit);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under two thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(8'h04, 8'h03);
    rdc(8'h00, 8'h00);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].wr ? rows[i].d : 8'h00);
      if (!rows[i].wr) chk(rd, 32'(rows[i].d));
      chk(32'(err), 32'(rows[i].e));
    end
    // blink group apart from on/off group, cleared alone
    apb(1'b1, 8'h00, 8'h08);
    apb(1'b1, 8'h10, 8'h03);
    rdc(8'h10, 8'h03);
    apb(1'b1, 8'h00, 8'h0A);
    apb(1'b0, 8'h00, 8'h00);
    chk(rd & 32'h0000_007F, 32'h0000_0008);
    rdc(8'h10, 8'h00);
    apb(1'b1, 8'h00, 8'h00);
    rdc(8'h10, 8'h0F);
    // display, blank and pin gating
    chk(32'(fp_display), 32'h0000_0001);
    count_lit();
    chk(32'(lit), 32'h0000_0030);
    apb(1'b1, 8'h00, 8'h01);
    count_lit();
    chk(32'(lit), 32'h0000_0000);
    chk(32'(bp_drive), 32'h0000_000F);
    rdc(8'h10, 8'h0F);
    apb(1'b1, 8'h00, 8'h00);
    count_lit();
    chk(32'(lit), 32'h0000_0030);
    apb(1'b1, 8'h04, 8'h23);
    repeat (2) @(posedge core_clk);
    chk(32'(fp_display), 32'h0000_0000);
    // every duty code, reserved one included
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 8'h04, 8'h80 | 8'(d));
      count_lit();
      chk(32'(bp_drive), d == 0 ? 32'h0000_0000 : 32'(4'hF >> (3 - d)));
      chk(32'(lit), d == 0 ? 32'h0000_0000 : 32'h0000_0030);
    end
    // frame flag: set, clear refused without read, masked, then cleared
    apb(1'b1, 8'h04, 8'hA3);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, 8'h04, 8'hA0);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h00, 8'h80);
    rdc(8'h00, 8'h80);
    apb(1'b1, 8'h04, 8'h80);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, 8'h04, 8'hA0);
    apb(1'b1, 8'h00, 8'h80);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0000_0000);
    rdc(8'h00, 8'h00);
    // blink: cells with blink enable go dark every other pair of frames
    apb(1'b1, 8'h00, 8'h08);
    apb(1'b1, 8'h10, 8'h03);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h04, 8'hC3);
    repeat (48) @(posedge core_clk);
    lit = 0;
    // one full blink period, so the sum does not depend on where it starts
    repeat (64) begin
      @(posedge core_clk);
      lit += $countones(seg_lit);
    end
    chk(32'(lit), 32'h0000_0030);
    // clear with the on/off group selected erases the whole display
    apb(1'b1, 8'h00, 8'h02);
    rdc(8'h10, 8'h00);
    rdc(8'h14, 8'h00);
    count_lit();
    chk(32'(lit), 32'h0000_0000);
    // reset in mid-run puts pins and registers back to their reset values
    resetn <= 1'b0;
    @(posedge core_clk);
    chk(32'({bp_drive, fp_display}), 32'h0000_0000);
    resetn <= 1'b1;
    rdc(8'h04, 8'h03);
    rdc(8'h10, 8'h00);
    end_of_test();
  end
endmodule
